// [hdl/swcfg_if.sv]
// carrier for the filtered switch levels between filter and decoder
interface swcfg_if #(parameter int WIDTH = 16);
  logic [WIDTH-1:0] stable;
  logic             update;
  modport source (output stable, output update);
  modport sink   (input  stable, input  update);
endinterface : swcfg_if

// [hdl/swcfg_pkg.sv]
// shared constants and types for the switch configuration decoder
package swcfg_pkg;
  localparam int          SWITCH_COUNT     = 16;
  localparam int          STEADY_CYCLES    = 16;
  localparam int          STEADY_WIDTH     = 5;
  // bank 1 positions
  localparam int          BIT_FIBER_MAN    = 0;
  localparam int          BIT_UTP_MAN      = 1;
  localparam int          BIT_SPEED_10_100 = 2;
  localparam int          BIT_SPEED_10     = 3;
  localparam int          BIT_HALF_DUPLEX  = 4;
  localparam int          BIT_LINK_SEL_0   = 5;
  localparam int          BIT_LINK_SEL_1   = 6;
  localparam int          BIT_LINK_SEL_2   = 7;
  // bank 2 positions
  localparam int          BIT_BP0_EN       = 8;
  localparam int          BIT_BP1_EN       = 9;
  localparam int          BIT_PAUSE_ON     = 10;
  localparam int          BIT_SLAVE_ONLY   = 11;
  localparam int          BIT_XOVER_MAN    = 12;
  localparam int          BIT_XOVER_CROSS  = 13;
  localparam int          BIT_RSVD_0       = 14;
  localparam int          BIT_RSVD_1       = 15;
  localparam logic [15:0] SWITCH_RESET     = 16'h0000;

  typedef enum logic [2:0] {
    LINK_SEGMENT        = 3'b000,
    LINK_PROPAGATE      = 3'b001,
    LINK_FAULT_SEGMENT  = 3'b010,
    LINK_FAULT_PROPAGATE = 3'b011,
    LINK_SYMMETRIC      = 3'b100
  } link_mode_type;
endpackage : swcfg_pkg

// [hdl/switch_config_decoder.sv]
// decodes the configuration switch banks into port and management controls

// What this block does
// - all link selectors default gives segment mode
// - only selector 0 moved gives propagate
// - only selector 1 gives fault detect segment
// - selectors 0 and 1 give fault detect propagate
// - only selector 2 gives symmetric fault detect
// - selector 2 with others falls back segment
// - port 0 isolated at default, enabled moved
// - port 1 isolated at default, enabled moved
// - pause switch off advertises no twisted-pair pause
// - pause switch on advertises pause capability
// - forced twisted-pair mode disables pause
// - fiber pause follows its autonegotiation switch
// - default negotiates mastership; moved means slave only
// - auto crossover only while twisted-pair autonegotiates
// - manual mode exactly when manual and 10-100
// - crossover select default enables auto crossover
// - manual crossover default straight, moved crossed
// - gigabit forces autonegotiation, ignores speed switch
module switch_config_decoder #(
  parameter int STEADY = swcfg_pkg::STEADY_CYCLES
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic [15:0] SWITCHES_IN,
  output logic [2:0]       LINK_MODE_OUT,
  output logic             SEGMENT_MODE_OUT,
  output logic             PROPAGATE_MODE_OUT,
  output logic             REMOTE_FAULT_DETECT_OUT,
  output logic             SYMMETRIC_FAULT_DETECT_OUT,
  output logic             ILLEGAL_LINK_SEL_OUT,
  output logic             BP_PORT0_ISOLATED_OUT,
  output logic             BP_PORT1_ISOLATED_OUT,
  output logic             UTP_AUTONEG_OUT,
  output logic             UTP_GIGABIT_OUT,
  output logic             UTP_SPEED_100_OUT,
  output logic             UTP_FULL_DUPLEX_OUT,
  output logic             UTP_PAUSE_ADV_OUT,
  output logic             FIBER_AUTONEG_OUT,
  output logic             FIBER_PAUSE_ADV_OUT,
  output logic             MASTERSHIP_AUTO_OUT,
  output logic             SLAVE_ONLY_OUT,
  output logic             AUTO_CROSSOVER_OUT,
  output logic             MANUAL_CROSSED_OUT,
  output logic             RESERVED_MOVED_OUT,
  output logic             CONFIG_UPDATE_OUT
);
  swcfg_if #(.WIDTH(swcfg_pkg::SWITCH_COUNT)) sw_if ();

  switch_steady_filter #(
    .WIDTH  (swcfg_pkg::SWITCH_COUNT),
    .STEADY (STEADY)
  ) u_filter (
    .clk_in (CLK_IN),
    .rst_in (RST_IN),
    .raw_in (SWITCHES_IN),
    .out_if (sw_if.source)
  );

  logic [15:0]              sw;
  swcfg_pkg::link_mode_type link_d;
  logic                     illegal_d;
  logic                     utp_an_d;
  logic                     autoneg_sel;
  logic                     gigabit_sel;
  assign sw = sw_if.stable;
  assign autoneg_sel = !sw[swcfg_pkg::BIT_UTP_MAN];
  assign gigabit_sel = !sw[swcfg_pkg::BIT_SPEED_10_100];
  // gigabit always negotiates; manual only with manual and 10-100
  assign utp_an_d = autoneg_sel || gigabit_sel;

  always_comb begin
    link_d    = swcfg_pkg::LINK_SEGMENT;
    illegal_d = 1'b0;
    case ({sw[swcfg_pkg::BIT_LINK_SEL_2], sw[swcfg_pkg::BIT_LINK_SEL_1],
           sw[swcfg_pkg::BIT_LINK_SEL_0]})
      3'h0:    link_d = swcfg_pkg::LINK_SEGMENT;
      3'h1:    link_d = swcfg_pkg::LINK_PROPAGATE;
      3'h2:    link_d = swcfg_pkg::LINK_FAULT_SEGMENT;
      3'h3:    link_d = swcfg_pkg::LINK_FAULT_PROPAGATE;
      3'h4:    link_d = swcfg_pkg::LINK_SYMMETRIC;
      default: begin
        link_d    = swcfg_pkg::LINK_SEGMENT;
        illegal_d = 1'b1;
      end
    endcase
  end

  // outputs only move when the filtered switches change
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      LINK_MODE_OUT        <= swcfg_pkg::LINK_SEGMENT;
      ILLEGAL_LINK_SEL_OUT <= 1'b0;
    end else begin
      LINK_MODE_OUT        <= link_d;
      ILLEGAL_LINK_SEL_OUT <= illegal_d;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      SEGMENT_MODE_OUT           <= 1'b1;
      PROPAGATE_MODE_OUT         <= 1'b0;
      REMOTE_FAULT_DETECT_OUT    <= 1'b0;
      SYMMETRIC_FAULT_DETECT_OUT <= 1'b0;
    end else begin
      SEGMENT_MODE_OUT        <= (link_d == swcfg_pkg::LINK_SEGMENT) ||
                                 (link_d == swcfg_pkg::LINK_FAULT_SEGMENT);
      PROPAGATE_MODE_OUT      <= (link_d == swcfg_pkg::LINK_PROPAGATE) ||
                                 (link_d == swcfg_pkg::LINK_FAULT_PROPAGATE);
      REMOTE_FAULT_DETECT_OUT <= (link_d == swcfg_pkg::LINK_FAULT_SEGMENT) ||
                                 (link_d == swcfg_pkg::LINK_FAULT_PROPAGATE);
      SYMMETRIC_FAULT_DETECT_OUT <= (link_d == swcfg_pkg::LINK_SYMMETRIC);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      BP_PORT0_ISOLATED_OUT <= 1'b1;
      BP_PORT1_ISOLATED_OUT <= 1'b1;
    end else begin
      BP_PORT0_ISOLATED_OUT <= !sw[swcfg_pkg::BIT_BP0_EN];
      BP_PORT1_ISOLATED_OUT <= !sw[swcfg_pkg::BIT_BP1_EN];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      UTP_AUTONEG_OUT     <= 1'b1;
      UTP_GIGABIT_OUT     <= 1'b1;
      UTP_SPEED_100_OUT   <= 1'b1;
      UTP_FULL_DUPLEX_OUT <= 1'b1;
      UTP_PAUSE_ADV_OUT   <= 1'b0;
      FIBER_AUTONEG_OUT   <= 1'b1;
      FIBER_PAUSE_ADV_OUT <= 1'b1;
    end else begin
      UTP_AUTONEG_OUT     <= utp_an_d;
      UTP_GIGABIT_OUT     <= gigabit_sel;
      // speed switch means nothing at gigabit
      UTP_SPEED_100_OUT   <= gigabit_sel || !sw[swcfg_pkg::BIT_SPEED_10];
      UTP_FULL_DUPLEX_OUT <= !sw[swcfg_pkg::BIT_HALF_DUPLEX];
      // pause advert needs both the switch and negotiation
      UTP_PAUSE_ADV_OUT   <= sw[swcfg_pkg::BIT_PAUSE_ON] && utp_an_d;
      FIBER_AUTONEG_OUT   <= !sw[swcfg_pkg::BIT_FIBER_MAN];
      FIBER_PAUSE_ADV_OUT <= !sw[swcfg_pkg::BIT_FIBER_MAN];
    end
  end

  // arbitration itself lives in management firmware; this only gates entry
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      MASTERSHIP_AUTO_OUT <= 1'b1;
      SLAVE_ONLY_OUT      <= 1'b0;
    end else begin
      MASTERSHIP_AUTO_OUT <= !sw[swcfg_pkg::BIT_SLAVE_ONLY];
      SLAVE_ONLY_OUT      <= sw[swcfg_pkg::BIT_SLAVE_ONLY];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      AUTO_CROSSOVER_OUT <= 1'b1;
      MANUAL_CROSSED_OUT <= 1'b0;
    end else begin
      AUTO_CROSSOVER_OUT <= !sw[swcfg_pkg::BIT_XOVER_MAN] && utp_an_d;
      // forced mode without auto crossover falls to the manual wiring switch
      MANUAL_CROSSED_OUT <= (sw[swcfg_pkg::BIT_XOVER_MAN] || !utp_an_d) &&
                            sw[swcfg_pkg::BIT_XOVER_CROSS];
    end
  end

  // flag for software only; reserved positions change nothing here
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      RESERVED_MOVED_OUT <= 1'b0;
      CONFIG_UPDATE_OUT  <= 1'b0;
    end else begin
      RESERVED_MOVED_OUT <= sw[swcfg_pkg::BIT_RSVD_0] || sw[swcfg_pkg::BIT_RSVD_1];
      CONFIG_UPDATE_OUT  <= sw_if.update;
    end
  end

  sequence s_selector(logic [2:0] v);
    {sw[swcfg_pkg::BIT_LINK_SEL_2], sw[swcfg_pkg::BIT_LINK_SEL_1],
     sw[swcfg_pkg::BIT_LINK_SEL_0]} == v;
  endsequence

  property p_segment;
    @(posedge CLK_IN) disable iff (RST_IN)
      s_selector(3'h0) |=> LINK_MODE_OUT == 3'b000 && SEGMENT_MODE_OUT;
  endproperty
  a_segment: assert property (p_segment) else $error("segment mode wrong");

  property p_propagate;
    @(posedge CLK_IN) disable iff (RST_IN)
      s_selector(3'h1) |=> PROPAGATE_MODE_OUT && !REMOTE_FAULT_DETECT_OUT;
  endproperty
  a_propagate: assert property (p_propagate) else $error("propagate mode wrong");

  property p_fault_segment;
    @(posedge CLK_IN) disable iff (RST_IN)
      s_selector(3'h2) |=> REMOTE_FAULT_DETECT_OUT && SEGMENT_MODE_OUT;
  endproperty
  a_fault_segment: assert property (p_fault_segment) else $error("fault segment wrong");

  property p_fault_propagate;
    @(posedge CLK_IN) disable iff (RST_IN)
      s_selector(3'h3) |=> REMOTE_FAULT_DETECT_OUT && PROPAGATE_MODE_OUT;
  endproperty
  a_fault_propagate: assert property (p_fault_propagate) else $error("fault propagate");

  property p_symmetric;
    @(posedge CLK_IN) disable iff (RST_IN)
      s_selector(3'h4) |=> SYMMETRIC_FAULT_DETECT_OUT && !SEGMENT_MODE_OUT;
  endproperty
  a_symmetric: assert property (p_symmetric) else $error("symmetric mode wrong");

  property p_illegal;
    @(posedge CLK_IN) disable iff (RST_IN)
      (sw[swcfg_pkg::BIT_LINK_SEL_2] &&
       (sw[swcfg_pkg::BIT_LINK_SEL_1] || sw[swcfg_pkg::BIT_LINK_SEL_0]))
      |=> ILLEGAL_LINK_SEL_OUT && SEGMENT_MODE_OUT && !REMOTE_FAULT_DETECT_OUT;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal fallback wrong");

  property p_bp_ports;
    @(posedge CLK_IN) disable iff (RST_IN)
      ##1 BP_PORT0_ISOLATED_OUT != $past(sw[swcfg_pkg::BIT_BP0_EN]) &&
          BP_PORT1_ISOLATED_OUT != $past(sw[swcfg_pkg::BIT_BP1_EN]);
  endproperty
  a_bp_ports: assert property (p_bp_ports) else $error("backplane isolation wrong");

  property p_pause_forced;
    @(posedge CLK_IN) disable iff (RST_IN)
      (!autoneg_sel && !gigabit_sel) || !sw[swcfg_pkg::BIT_PAUSE_ON] |=> !UTP_PAUSE_ADV_OUT;
  endproperty
  a_pause_forced: assert property (p_pause_forced) else $error("pause advertised");

  property p_crossover_manual;
    @(posedge CLK_IN) disable iff (RST_IN)
      (!autoneg_sel && !gigabit_sel) |=> !AUTO_CROSSOVER_OUT && !UTP_AUTONEG_OUT;
  endproperty
  a_crossover_manual: assert property (p_crossover_manual) else $error("auto crossover");

  property p_slave;
    @(posedge CLK_IN) disable iff (RST_IN)
      ##1 (SLAVE_ONLY_OUT == $past(sw[swcfg_pkg::BIT_SLAVE_ONLY])) &&
          (SLAVE_ONLY_OUT == !MASTERSHIP_AUTO_OUT);
  endproperty
  a_slave: assert property (p_slave) else $error("mastership outputs disagree");

  property p_filter_hold;
    @(posedge CLK_IN) disable iff (RST_IN)
      !sw_if.update |-> $stable(sw);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("moved without update");

  sequence s_levels_moved;
    !$stable(sw);
  endsequence

  sequence s_announced;
    sw_if.update ##1 CONFIG_UPDATE_OUT;
  endsequence

  // a filtered change is flagged now and announced on the next edge
  property p_change_announced;
    @(posedge CLK_IN) disable iff (RST_IN)
      s_levels_moved |-> s_announced;
  endproperty
  a_change_announced: assert property (p_change_announced) else $error("no update");

  property p_update_follow;
    @(posedge CLK_IN) disable iff (RST_IN)
      ##1 CONFIG_UPDATE_OUT == $past(sw_if.update);
  endproperty
  a_update_follow: assert property (p_update_follow) else $error("update pulse wrong");

  property p_pause_adv;
    @(posedge CLK_IN) disable iff (RST_IN)
      sw[swcfg_pkg::BIT_PAUSE_ON] && (autoneg_sel || gigabit_sel) |=> UTP_PAUSE_ADV_OUT;
  endproperty
  a_pause_adv: assert property (p_pause_adv) else $error("pause not advertised");

  property p_fiber_pause;
    @(posedge CLK_IN) disable iff (RST_IN)
      ##1 (FIBER_PAUSE_ADV_OUT == !$past(sw[swcfg_pkg::BIT_FIBER_MAN])) &&
          (FIBER_AUTONEG_OUT == FIBER_PAUSE_ADV_OUT);
  endproperty
  a_fiber_pause: assert property (p_fiber_pause) else $error("fiber pause wrong");

  property p_gigabit_autoneg;
    @(posedge CLK_IN) disable iff (RST_IN)
      gigabit_sel |=> UTP_AUTONEG_OUT && UTP_GIGABIT_OUT && UTP_SPEED_100_OUT;
  endproperty
  a_gigabit_autoneg: assert property (p_gigabit_autoneg) else $error("gigabit forced");

  property p_auto_xover;
    @(posedge CLK_IN) disable iff (RST_IN)
      !sw[swcfg_pkg::BIT_XOVER_MAN] && (autoneg_sel || gigabit_sel)
      |=> AUTO_CROSSOVER_OUT && !MANUAL_CROSSED_OUT;
  endproperty
  a_auto_xover: assert property (p_auto_xover) else $error("crossover off");

  property p_manual_wiring;
    @(posedge CLK_IN) disable iff (RST_IN)
      sw[swcfg_pkg::BIT_XOVER_MAN] |=> !AUTO_CROSSOVER_OUT &&
        (MANUAL_CROSSED_OUT == $past(sw[swcfg_pkg::BIT_XOVER_CROSS]));
  endproperty
  a_manual_wiring: assert property (p_manual_wiring) else $error("manual wiring wrong");
endmodule : switch_config_decoder

// [hdl/switch_steady_filter.sv]
// per-switch steadiness filter feeding the decoder
module switch_steady_filter #(
  parameter int WIDTH  = swcfg_pkg::SWITCH_COUNT,
  parameter int STEADY = swcfg_pkg::STEADY_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [WIDTH-1:0] raw_in,
  swcfg_if.source         out_if
);
  // per-bit nets, so every bit keeps a single driver of its own
  wire [WIDTH-1:0] stable_bits;
  wire [WIDTH-1:0] update_bits;
  assign out_if.stable = stable_bits;
  assign out_if.update = |update_bits;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic                                  s1_q;
      logic                                  s2_q;
      logic [swcfg_pkg::STEADY_WIDTH-1:0]    cnt_q;
      logic                                  stable_q;
      logic                                  upd_q;
      assign stable_bits[g] = stable_q;
      assign update_bits[g] = upd_q;
      // two flops, then only s2 is compared
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= raw_in[g];
          s2_q <= s1_q;
        end
      end
      // level must hold for STEADY cycles before it is accepted
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          cnt_q       <= '0;
          stable_q    <= swcfg_pkg::SWITCH_RESET[g];
          upd_q       <= 1'b0;
        end else begin
          upd_q <= 1'b0;
          if (s2_q == stable_q) begin
            cnt_q <= '0;
          end else if (cnt_q == (swcfg_pkg::STEADY_WIDTH)'(STEADY - 1)) begin
            cnt_q       <= '0;
            stable_q    <= s2_q;
            upd_q       <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      end
    end
  endgenerate
endmodule : switch_steady_filter

// [sim/switch_bank_model.sv]
// installer-side model of the two configuration switch banks
module switch_bank_model (
  input  wire logic        clk_in,
  output logic      [15:0] switches_out
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [15:0] RSVD_MASK = 16'hC000;

  // single unit on the link, so no fault detect peer is ever paired
  // power-up in all-default positions, segment mode first
  initial switches_out = swcfg_pkg::SWITCH_RESET;

  // factory-only positions never leave default, whatever is asked
  task automatic set_bank(input logic [15:0] value);
    @(posedge clk_in);
    #1;
    switches_out = value & ~RSVD_MASK;
  endtask : set_bank

  // contact bounce: one switch flips for fewer cycles than the filter needs
  task automatic bounce(input int idx, input int cycles);
    @(posedge clk_in);
    #1;
    switches_out[idx] = ~switches_out[idx];
    repeat (cycles) @(posedge clk_in);
    #1;
    switches_out[idx] = ~switches_out[idx];
  endtask : bounce
endmodule : switch_bank_model

// [sim/tb_top.sv]
// self-checking bench for the switch configuration decoder
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int STEADY = 4;

  logic        clk;
  logic        rst;
  logic [15:0] sw;
  logic [15:0] cur;
  logic [2:0]  link_mode;
  logic        seg, prop, fault_det, sym_det, illegal, iso0, iso1, utp_an, utp_gig, utp_100;
  logic        utp_fdx, utp_pause, fib_an, fib_pause, mast, slave, auto_x, crossed;
  logic        rsvd, upd;
  int          errors;
  int          total_checks;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  switch_bank_model bank (.clk_in(clk), .switches_out(sw));

  switch_config_decoder #(.STEADY(STEADY)) dut (
    .CLK_IN                     (clk),
    .RST_IN                     (rst),
    .SWITCHES_IN                (sw),
    .LINK_MODE_OUT              (link_mode),
    .SEGMENT_MODE_OUT           (seg),
    .PROPAGATE_MODE_OUT         (prop),
    .REMOTE_FAULT_DETECT_OUT    (fault_det),
    .SYMMETRIC_FAULT_DETECT_OUT (sym_det),
    .ILLEGAL_LINK_SEL_OUT       (illegal),
    .BP_PORT0_ISOLATED_OUT      (iso0),
    .BP_PORT1_ISOLATED_OUT      (iso1),
    .UTP_AUTONEG_OUT            (utp_an),
    .UTP_GIGABIT_OUT            (utp_gig),
    .UTP_SPEED_100_OUT          (utp_100),
    .UTP_FULL_DUPLEX_OUT        (utp_fdx),
    .UTP_PAUSE_ADV_OUT          (utp_pause),
    .FIBER_AUTONEG_OUT          (fib_an),
    .FIBER_PAUSE_ADV_OUT        (fib_pause),
    .MASTERSHIP_AUTO_OUT        (mast),
    .SLAVE_ONLY_OUT             (slave),
    .AUTO_CROSSOVER_OUT         (auto_x),
    .MANUAL_CROSSED_OUT         (crossed),
    .RESERVED_MOVED_OUT         (rsvd),
    .CONFIG_UPDATE_OUT          (upd)
  );

  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic cmp_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : cmp_bit

  task automatic cmp_mode(input string name, input logic [2:0] exp, input logic [2:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask : cmp_mode

  // expectations come from the switch setting alone
  task automatic check_all;
    logic       ill;
    logic       an;
    logic [2:0] m;
    ill = cur[7] & (cur[5] | cur[6]);
    m   = ill ? 3'h0 : {cur[7], cur[6], cur[5]};
    an  = ~(cur[1] & cur[2]);
    cmp_mode("link_mode", m, link_mode);
    cmp_bit("illegal", ill, illegal);
    cmp_bit("segment", m == 3'h0 || m == 3'h2, seg);
    cmp_bit("propagate", m == 3'h1 || m == 3'h3, prop);
    cmp_bit("remote_fault", m == 3'h2 || m == 3'h3, fault_det);
    cmp_bit("symmetric", m == 3'h4, sym_det);
    cmp_bit("port0_isolated", ~cur[8], iso0);
    cmp_bit("port1_isolated", ~cur[9], iso1);
    cmp_bit("utp_autoneg", an, utp_an);
    cmp_bit("utp_gigabit", ~cur[2], utp_gig);
    cmp_bit("utp_speed_100", ~cur[2] | ~cur[3], utp_100);
    cmp_bit("utp_full_duplex", ~cur[4], utp_fdx);
    cmp_bit("utp_pause", cur[10] & an, utp_pause);
    cmp_bit("fiber_autoneg", ~cur[0], fib_an);
    cmp_bit("fiber_pause", ~cur[0], fib_pause);
    cmp_bit("mastership_auto", ~cur[11], mast);
    cmp_bit("slave_only", cur[11], slave);
    cmp_bit("auto_crossover", ~cur[12] & an, auto_x);
    cmp_bit("manual_crossed", (cur[12] | ~an) & cur[13], crossed);
    cmp_bit("reserved_moved", 1'b0, rsvd);
  endtask : check_all

  // set the banks, wait for the filtered update, then judge every output
  task automatic apply(input logic [15:0] value);
    int n = 0;
    bank.set_bank(value);
    if ((value & 16'h3FFF) !== cur) begin
      cur = value & 16'h3FFF;
      while (upd !== 1'b1) begin
        @(posedge clk);
        #1;
        n++;
        if (n > 50) begin
          errors++;
          $display("Error config_update expected 1 seen %b", upd);
          results();
        end
      end
    end
    check_all();
  endtask : apply

  task automatic test_link_modes;
    for (int i = 0; i < 8; i++) begin
      apply({8'h00, i[2:0], 5'h00});
    end
    apply(16'h0000);
  endtask : test_link_modes

  task automatic test_ports_mastership;
    apply(16'h0100);
    apply(16'h0200);
    apply(16'h0B00);
    apply(16'h0000);
  endtask : test_ports_mastership

  // fiber manual, utp manual, speed, duplex and pause in every combination
  task automatic test_negotiation;
    for (int i = 0; i < 64; i++) begin
      apply({5'h00, i[5], 5'h00, i[4:0]});
    end
    apply(16'h0000);
  endtask : test_negotiation

  task automatic test_crossover;
    for (int i = 0; i < 8; i++) begin
      apply({2'b00, i[1], i[0], 8'h00, 1'b0, i[2], i[2], 1'b0});
    end
    apply(16'h0000);
  endtask : test_crossover

  // a bounce shorter than the steady window must leave no trace
  task automatic test_bounce;
    logic seen = 1'b0;
    bank.bounce(8, STEADY - 2);
    repeat (3 * STEADY + 10) begin
      @(posedge clk);
      #1;
      seen = seen | (upd === 1'b1);
    end
    cmp_bit("bounce_update", 1'b0, seen);
    check_all();
    apply(16'h0100);
  endtask : test_bounce

  initial begin
    errors = 0;
    total_checks = 0;
    cur = 16'h0000;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    check_all();
    test_link_modes();
    test_ports_mastership();
    test_negotiation();
    test_crossover();
    test_bounce();
    results();
  end
endmodule : tb_top
